// >>> rtl/mac_saturate_round.sv
// overflow, saturation and rounding stage of the multiply/accumulate unit
// What this block does
// RULE_01: every multiply/accumulate operation rewrites the mac overflow flag.
// RULE_02: flag is set when top nine accumulator bits are not all equal.
// RULE_03: saturate: no change if flag clear, else full-scale by guard sign.
// RULE_04: saturation happens only on the explicit saturate instruction.
// RULE_05: software saturates only after a whole accumulation sequence.
// RULE_06: software keeps overflows below 256 so guard sign stays true.
// RULE_07: rounding requested by instruction acts at the bit 15/16 boundary.
// RULE_08: rounded result goes to feedback (16 bits) or accumulator (40 bits).
// RULE_09: rounding adds one at bit 15 with full carry upward.
// RULE_10: unbiased midpoint 0x8000 forces bit 16 of the result to zero.
// RULE_11: midpoint check runs on every rounding operation.
// RULE_12: control bit 12 picks unbiased (0) or biased (1) rounding.
// RULE_13: biased mode rounds every midpoint upward.
// RULE_14: accumulator is low word, middle word and 8-bit guard byte.
// RULE_15: saturate and rounded accumulate finish in one cycle.
module mac_saturate_round
  import mac_sat_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire mac_req_t req,
  output logic [ACC_W-1:0] accum_result,
  output logic [WORD_W-1:0] feedback_result_reg,
  output logic mac_overflow_flag,
  output logic irq
);

  logic [ACC_W-1:0] accum_reg, accum_next;
  logic [WORD_W-1:0] feedback_reg, feedback_next;
  logic flag_reg, flag_next;
  logic biased_reg;
  logic [EV_W-1:0] irq_status_reg, irq_status_next;
  logic [EV_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // RULE_14 accumulator fields
  wire [WORD_W-1:0] accum_low_word = accum_reg[MID_LSB-1:LOW_LSB];
  wire [WORD_W-1:0] accum_mid_word = accum_reg[GUARD_LSB-1:MID_LSB];
  wire [GUARD_W-1:0] accum_guard_byte = accum_reg[GUARD_MSB:GUARD_LSB];

  // instruction decode
  wire is_mul = req.valid && (req.op == OP_MUL);
  wire is_add = req.valid && (req.op == OP_MAC_ADD);
  wire is_sub = req.valid && (req.op == OP_MAC_SUB);
  wire is_clear = req.valid && (req.op == OP_CLEAR);
  wire is_sat = req.valid && (req.op == OP_SATURATE);
  wire mac_op = is_mul || is_add || is_sub || is_clear;
  wire to_accum = mac_op && !req.to_feedback;
  wire to_feedback = mac_op && req.to_feedback;

  // raw adder/subtracter result
  wire [ACC_W-1:0] sum_add = accum_reg + req.product;
  wire [ACC_W-1:0] sum_sub = accum_reg - req.product;
  wire [ACC_W-1:0] raw_result = is_mul ? req.product :
                                is_add ? sum_add :
                                is_sub ? sum_sub : ACC_RESET;

  // RULE_07 round on request
  wire [ACC_W-1:0] rounded_result;
  round_unit u_round (
    .value_in(raw_result),
    .biased_round_select(biased_reg),
    .value_out(rounded_result)
  );
  wire [ACC_W-1:0] final_result = req.round_request ? rounded_result : raw_result;

  // RULE_02 nine-bit sign check
  wire [8:0] top_nine = final_result[GUARD_MSB:SIGN32_BIT];
  wire result_overflow = !((&top_nine) || !(|top_nine));

  // RULE_03 saturation target
  wire [ACC_W-1:0] sat_value = accum_reg[GUARD_MSB] ? SAT_NEGATIVE : SAT_POSITIVE;
  wire sat_applies = is_sat && flag_reg;

  // RULE_04 only explicit saturate
  // RULE_08 accumulator or feedback
  // RULE_15 single-cycle write
  assign accum_next = sat_applies ? sat_value :
                      to_accum ? final_result : accum_reg;
  assign feedback_next = to_feedback ? final_result[GUARD_LSB-1:MID_LSB] : feedback_reg;
  // RULE_01 flag on every mac op
  assign flag_next = mac_op ? result_overflow : flag_reg;

  // register bus decode: request taken on the first cycle of a strobe
  wire bus_take = wb_cyc_i && wb_stb_i && !ack_reg;
  wire bus_write = bus_take && wb_we_i;
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wdata = wb_dat_i & lane_mask;
  wire wr_ctrl = bus_write && (wb_adr_i == OFS_ROUND_CTRL) && wb_sel_i[1];
  wire wr_status = bus_write && (wb_adr_i == OFS_IRQ_STATUS);
  wire wr_mask = bus_write && (wb_adr_i == OFS_IRQ_MASK);

  // sticky events: a set in the same cycle as a clear wins
  wire [EV_W-1:0] ev_set = {sat_applies, mac_op && result_overflow};
  wire [EV_W-1:0] ev_clear = wr_status ? wdata[EV_W-1:0] : '0;
  assign irq_status_next = (irq_status_reg & ~ev_clear) | ev_set;

  wire [31:0] arith_status_reg = {{(31-MAC_OVERFLOW_BIT){1'b0}}, flag_reg};
  wire [31:0] ctrl_word = {{(31-BIASED_ROUND_BIT){1'b0}}, biased_reg,
                           {BIASED_ROUND_BIT{1'b0}}};
  wire [31:0] read_mux =
    (wb_adr_i == OFS_ROUND_CTRL) ? ctrl_word :
    (wb_adr_i == OFS_ARITH_STATUS) ? arith_status_reg :
    (wb_adr_i == OFS_IRQ_STATUS) ? {{(32-EV_W){1'b0}}, irq_status_reg} :
    (wb_adr_i == OFS_IRQ_MASK) ? {{(32-EV_W){1'b0}}, irq_mask_reg} :
    (wb_adr_i == OFS_ACC_LOW) ? {16'h0000, accum_low_word} :
    (wb_adr_i == OFS_ACC_MID) ? {16'h0000, accum_mid_word} :
    (wb_adr_i == OFS_ACC_GUARD) ? {24'h00_0000, accum_guard_byte} :
    (wb_adr_i == OFS_FEEDBACK) ? {16'h0000, feedback_reg} : 32'h0000_0000;

  // datapath state
  always_ff @(posedge clock) begin
    if (rst) begin
      accum_reg <= ACC_RESET;
      feedback_reg <= FEEDBACK_RESET;
      flag_reg <= 1'b0;
    end else begin
      accum_reg <= accum_next;
      feedback_reg <= feedback_next;
      flag_reg <= flag_next;
    end
  end

  // RULE_12 rounding mode control
  always_ff @(posedge clock) begin
    if (rst) begin
      biased_reg <= BIASED_RESET;
    end else if (wr_ctrl) begin
      biased_reg <= wdata[BIASED_ROUND_BIT];
    end
  end

  // interrupt status, mask and output; irq lags status by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status_reg <= '0;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_mask) begin
        irq_mask_reg <= wdata[EV_W-1:0];
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_take;
      if (bus_take && !wb_we_i) begin
        rdata_reg <= read_mux;
      end
    end
  end

  assign accum_result = accum_reg;
  assign feedback_result_reg = feedback_reg;
  assign mac_overflow_flag = flag_reg;
  assign irq = irq_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_sat_clear;
    is_sat && !flag_reg;
  endsequence
  sequence s_sat_pos;
    is_sat && flag_reg && !accum_reg[GUARD_MSB];
  endsequence
  sequence s_sat_neg;
    is_sat && flag_reg && accum_reg[GUARD_MSB];
  endsequence
  sequence s_midpoint_acc;
    to_accum && req.round_request && (raw_result[MID_LSB-1:LOW_LSB] == ROUND_MIDPOINT);
  endsequence

  a_flag_on_mac: assert property ( // RULE_02
    mac_op |=> mac_overflow_flag ==
      !((&$past(final_result[GUARD_MSB:SIGN32_BIT])) ||
        !(|$past(final_result[GUARD_MSB:SIGN32_BIT]))))
    else $error("overflow flag wrong after mac op");

  a_flag_hold_idle: assert property ( // RULE_01
    !mac_op |=> $stable(mac_overflow_flag))
    else $error("overflow flag changed without mac op");

  a_sat_no_change: assert property ( // RULE_03
    s_sat_clear |=> $stable(accum_result))
    else $error("saturate changed accumulator with flag clear");

  a_sat_full_pos: assert property ( // RULE_03
    s_sat_pos |=> accum_result == SAT_POSITIVE && irq_status_reg[EV_SATURATED_BIT])
    else $error("saturate did not give full-scale positive");

  a_sat_full_neg: assert property ( // RULE_03
    s_sat_neg |=> accum_result == SAT_NEGATIVE)
    else $error("saturate did not give full-scale negative");

  a_no_auto_sat: assert property ( // RULE_04
    !is_sat && !to_accum |=> $stable(accum_result))
    else $error("accumulator changed without instruction");

  a_round_unbiased_mid: assert property ( // RULE_10
    (s_midpoint_acc and !biased_reg) |=> accum_result ==
      (($past(raw_result) + ROUND_ADDEND) & ~(ACC_W'(1) << ROUND_FORCE_BIT)))
    else $error("unbiased midpoint not forced even");

  a_round_biased_up: assert property ( // RULE_13
    (s_midpoint_acc and biased_reg) |=> accum_result[GUARD_MSB:MID_LSB] ==
      $past(raw_result[GUARD_MSB:MID_LSB]) + 24'h00_0001)
    else $error("biased midpoint did not round up");

  a_round_plain: assert property ( // RULE_09
    to_accum && req.round_request && (raw_result[MID_LSB-1:LOW_LSB] != ROUND_MIDPOINT)
    |=> accum_result == $past(raw_result) + ROUND_ADDEND)
    else $error("plain rounding result wrong");

  a_round_feedback: assert property ( // RULE_08
    to_feedback |=> feedback_result_reg == $past(final_result[GUARD_LSB-1:MID_LSB])
      && $stable(accum_result))
    else $error("feedback write wrong or accumulator disturbed");

  a_irq_level: assert property (
    |(irq_status_reg & irq_mask_reg) |=> irq)
    else $error("interrupt not raised for unmasked event");

  a_bus_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // bus handshake: one wait state, never an answer without a request
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_status_read;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && (wb_adr_i == OFS_ARITH_STATUS);
  endsequence

  // plain loads without rounding, so the expected value is zero for clear and the product for multiply
  sequence s_plain_clear;
    is_clear && !req.to_feedback && !req.round_request;
  endsequence

  sequence s_plain_mul;
    is_mul && !req.to_feedback && !req.round_request;
  endsequence

  a_bus_ack_next: assert property (
    s_bus_take |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");

  a_ack_needs_req: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack given without a request");

  a_status_read: assert property ( // RULE_01
    s_status_read |=> wb_dat_o == {31'h0000_0000, $past(mac_overflow_flag)})
    else $error("status read does not show the overflow flag");

  a_clear_zero: assert property ( // RULE_02
    s_plain_clear |=> accum_result == ACC_RESET && !mac_overflow_flag)
    else $error("clear did not zero accumulator and flag");

  a_mul_load: assert property ( // RULE_08
    s_plain_mul |=> accum_result == $past(req.product))
    else $error("multiply did not load the product");

  a_ovf_event: assert property ( // RULE_02
    mac_op && result_overflow |=> irq_status_reg[EV_OVERFLOW_BIT])
    else $error("overflow event not recorded");

  a_sat_event: assert property ( // RULE_03
    s_sat_neg |=> irq_status_reg[EV_SATURATED_BIT])
    else $error("negative saturation event not recorded");

  a_ctrl_write: assert property ( // RULE_12
    wr_ctrl |=> biased_reg == $past(wdata[BIASED_ROUND_BIT]))
    else $error("rounding mode write not applied");

  a_irq_quiet: assert property (
    !(|(irq_status_reg & irq_mask_reg)) |=> !irq)
    else $error("interrupt raised without unmasked event");

endmodule // mac_saturate_round

// >>> common/mac_sat_pkg.sv
// shared constants and types for the mac saturation and rounding stage
package mac_sat_pkg;

  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int GUARD_W = 8;
  localparam int ADR_W = 8;

  // accumulator field positions
  localparam int LOW_LSB = 0;
  localparam int MID_LSB = 16;
  localparam int GUARD_LSB = 32;
  localparam int GUARD_MSB = 39;
  localparam int SIGN32_BIT = 31;

  // rounding constants
  localparam logic [ACC_W-1:0] ROUND_ADDEND = 40'h00_0000_8000;
  localparam logic [WORD_W-1:0] ROUND_MIDPOINT = 16'h8000;
  localparam int ROUND_FORCE_BIT = 16;

  // saturation values
  localparam logic [ACC_W-1:0] SAT_POSITIVE = 40'h00_7fff_ffff;
  localparam logic [ACC_W-1:0] SAT_NEGATIVE = 40'hff_8000_0000;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_ROUND_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_ARITH_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_ACC_LOW = 8'h10;
  localparam logic [ADR_W-1:0] OFS_ACC_MID = 8'h14;
  localparam logic [ADR_W-1:0] OFS_ACC_GUARD = 8'h18;
  localparam logic [ADR_W-1:0] OFS_FEEDBACK = 8'h1c;

  // field positions
  localparam int BIASED_ROUND_BIT = 12;
  localparam int MAC_OVERFLOW_BIT = 0;
  localparam int EV_OVERFLOW_BIT = 0;
  localparam int EV_SATURATED_BIT = 1;
  localparam int EV_W = 2;

  // reset values
  localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [WORD_W-1:0] FEEDBACK_RESET = 16'h0000;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic BIASED_RESET = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_MUL,
    OP_MAC_ADD,
    OP_MAC_SUB,
    OP_CLEAR,
    OP_SATURATE
  } mac_op_t;

  // one instruction from the sequencer, valid for the cycle it is presented
  typedef struct packed {
    logic valid;
    mac_op_t op;
    logic round_request;
    logic to_feedback;
    logic [ACC_W-1:0] product;
  } mac_req_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// >>> rtl/round_unit.sv
// rounding at the bit 15/16 boundary with midpoint correction
module round_unit
  import mac_sat_pkg::*;
(
  input wire logic [ACC_W-1:0] value_in,
  input wire logic biased_round_select,
  output logic [ACC_W-1:0] value_out
);

  logic [ACC_W-1:0] sum;
  logic midpoint;

  // RULE_09 add at fifteen
  assign sum = value_in + ROUND_ADDEND;
  // RULE_11 midpoint always checked
  assign midpoint = (value_in[MID_LSB-1:LOW_LSB] == ROUND_MIDPOINT);

  // RULE_10 clear bit sixteen
  // RULE_13 biased keeps carry
  always_comb begin
    value_out = sum;
    if (midpoint && !biased_round_select) begin
      value_out[ROUND_FORCE_BIT] = 1'b0;
    end
  end

endmodule // round_unit

// >>> dv/seq_model.sv
// instruction sequencer model that feeds the mac stage
module seq_model
  import mac_sat_pkg::*;
(
  input wire logic clock,
  output mac_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;

  initial req = '0;

  // one instruction per call, taken at the next rising edge; calls may run back to back
  // guard headroom
  // random callers keep products within 32 signed bits so short runs never reach the guard sign
  task automatic issue(input mac_op_t op, input logic rnd, input logic fb, input logic [39:0] p);
    req <= '{valid: 1'b1, op: op, round_request: rnd, to_feedback: fb, product: p};
    @(posedge clock);
  endtask

  task automatic idle();
    req.valid <= 1'b0;
  endtask
endmodule // seq_model

// >>> dv/mac_saturate_round_tb.sv
// self-checking bench for the mac saturation and rounding stage
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mac_saturate_round_tb import mac_sat_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 0;
  logic rst = 1;
  wb_req_t wb = '0;
  mac_req_t req;
  logic [31:0] rd, dat_o, r32, r8;
  logic [39:0] acc_o, m_acc = '0;
  logic [15:0] fb_o, m_fb = '0;
  logic flag_o, irq, ack, m_flag = 0, m_bias = 0, pend = 0;
  int miscompares = 0, tests_run = 0, cycles = 0, seed = 68463;
  logic [39:0] tv[7] = '{40'h00_0000_8000, 40'h00_0001_8000, 40'h00_0000_8001,
    40'h00_0001_8001, 40'h00_0000_7fff, 40'h00_0001_7fff, 40'h00_7fff_8000};

  initial forever #25 clock = ~clock;

  mac_saturate_round dut (.clock(clock), .rst(rst), .wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb),
    .wb_we_i(wb.we), .wb_adr_i(wb.adr), .wb_sel_i(wb.sel), .wb_dat_i(wb.dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .req(req), .accum_result(acc_o),
    .feedback_result_reg(fb_o), .mac_overflow_flag(flag_o), .irq(irq));
  seq_model u_seq (.clock(clock), .req(req));

  function automatic logic [39:0] rnd_fn(logic [39:0] v, logic b);
    logic [39:0] r;
    r = v + 40'h00_0000_8000;
    if (v[15:0] == 16'h8000 && !b) r[16] = 1'b0;
    return r;
  endfunction

  // reference model sees req before the edge, as the design does
  always @(posedge clock) begin
    logic [39:0] r;
    if (rst) begin
      m_acc = '0;
      m_fb = '0;
      m_flag = 0;
      pend = 0;
    end else if (req.valid) begin
      pend = 1;
      case (req.op)
        OP_MUL: r = req.product;
        OP_MAC_ADD: r = m_acc + req.product;
        OP_MAC_SUB: r = m_acc - req.product;
        default: r = '0;
      endcase
      if (req.op == OP_SATURATE) begin
        if (m_flag) m_acc = m_acc[39] ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
      end else if (req.op != OP_NONE) begin
        if (req.round_request) r = rnd_fn(r, m_bias);
        m_flag = !(&r[39:31] || ~|r[39:31]);
        if (req.to_feedback) m_fb = r[31:16];
        else m_acc = r;
      end
    end
  end

  // results are compared in the cycle after the instruction
  always @(negedge clock) if (pend) begin
    pend = 0;
    `CHK(acc_o, m_acc)
    `CHK(fb_o, m_fb)
    `CHK(flag_o, m_flag)
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_o;
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a <= 'h20; a += 4) rd_chk(8'(a), 32'h0);
    wb_xfer(1'b1, 8'h10, 32'h1234);
    rd_chk(8'h10, 32'h0);
    $display("test regs done");
    for (int b = 0; b < 2; b++) begin
      wb_xfer(1'b1, 8'h00, 32'(b) << 12);
      m_bias = b[0];
      rd_chk(8'h00, 32'(b) << 12);
      foreach (tv[i]) begin
        u_seq.issue(OP_MUL, 1'b1, 1'b0, tv[i]);
        u_seq.issue(OP_MUL, 1'b1, 1'b1, tv[i]);
      end
      u_seq.idle();
    end
    $display("test rounding done");
    wb_xfer(1'b1, 8'h00, 32'h0);
    m_bias = 0;
    repeat (40) begin
      repeat (8) begin
        r32 = $random(seed);
        r8 = $random(seed);
        u_seq.issue(mac_op_t'(3'd1 + r8[1:0]), r8[2], r8[3], {{8{r32[31]}}, r32});
      end
      u_seq.issue(OP_SATURATE, 1'b0, 1'b0, '0);
    end
    u_seq.idle();
    $display("test random done");
    wb_xfer(1'b1, 8'h08, 32'h3);
    wb_xfer(1'b1, 8'h0c, 32'h3);
    rd_chk(8'h0c, 32'h3);
    u_seq.issue(OP_MUL, 1'b0, 1'b0, 40'h01_0000_0000);
    u_seq.issue(OP_SATURATE, 1'b0, 1'b0, '0);
    u_seq.idle();
    rd_chk(8'h04, 32'h1);
    rd_chk(8'h08, 32'h3);
    `CHK(irq, 1'b1)
    rd_chk(8'h14, 32'h7fff);
    u_seq.issue(OP_MUL, 1'b0, 1'b0, 40'hfe_0000_0000);
    u_seq.issue(OP_SATURATE, 1'b0, 1'b0, '0);
    u_seq.idle();
    rd_chk(8'h18, 32'hff);
    wb_xfer(1'b1, 8'h08, 32'h3);
    @(negedge clock) `CHK(irq, 1'b0)
    wb_xfer(1'b1, 8'h0c, 32'h0);
    u_seq.issue(OP_MUL, 1'b0, 1'b0, 40'h01_0000_0000);
    u_seq.idle();
    repeat (3) @(negedge clock);
    `CHK(irq, 1'b0)
    rd_chk(8'h08, 32'h1);
    $display("test irq done");
    conclude();
  end
endmodule // mac_saturate_round_tb
